/* sadc_pkg.sv */
package sadc_pkg;
  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] sadc_off_control_one = 8'h00;
  localparam logic [7:0] sadc_off_control_two = 8'h04;
  localparam logic [7:0] sadc_off_control_three = 8'h08;
  localparam logic [7:0] sadc_off_pin_config_low = 8'h0C;
  localparam logic [7:0] sadc_off_pin_config_high = 8'h10;
  localparam logic [7:0] sadc_off_irq_status = 8'h14;
  localparam logic [7:0] sadc_off_irq_mask = 8'h18;
  localparam logic [7:0] sadc_off_result = 8'h1C;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int sadc_pos_module_on = 15;
  localparam int sadc_pos_resolution_select = 10;
  localparam int sadc_pos_format_lo = 8;
  localparam int sadc_pos_seq_lo = 5;
  localparam int sadc_pos_simultaneous = 3;
  localparam int sadc_pos_start = 1;
  localparam int sadc_pos_vref_lo = 13;
  localparam int sadc_pos_channels_lo = 8;
  localparam int sadc_pos_clock_div_lo = 0;
  localparam int sadc_pos_sample_time_lo = 8;
  // ****************************************************************
  // reset values and counts
  // ****************************************************************
  localparam logic [15:0] sadc_rst_control = 16'h0000;
  localparam logic [15:0] sadc_rst_pin_config = 16'h0000;
  localparam int sadc_num_inputs = 13;
  localparam int sadc_bits_low_res = 10;
  localparam int sadc_bits_high_res = 12;
  localparam int sadc_num_sh_low_res = 4;
  localparam logic [1:0] sadc_resp_okay = 2'h0;
  localparam logic [1:0] sadc_resp_slverr = 2'h2;
  // irq status bits
  localparam int sadc_irq_conv_done = 0;
endpackage : sadc_pkg

/* sadc_clock_div.sv */
`timescale 1ns/1ns
// ********************************************************************
// conversion clock enable divider
// ********************************************************************
module sadc_clock_div (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [7:0] divisor,
  output logic tick
);
  logic [7:0] count;
  wire logic wrap = (count >= divisor);

  // one pulse every divisor+1 cycles; held in reset while not running
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      count <= 8'h00;
      tick <= 1'b0;
    end else begin
      count <= wrap ? 8'h00 : count + 8'h01;
      tick <= wrap;
    end
  end
endmodule : sadc_clock_div

/* sadc_control.sv */
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
// Summary of operation
// - resolution bit picks 10-bit four-S/H mode (reset) or 12-bit one-S/H mode.
// - in 10-bit mode up to four inputs are sampled at one instant.
// - in 12-bit mode only one S/H exists, no simultaneous sampling.
// - input multiplexer selects among thirteen analog inputs, zero to twelve.
// - two pins serve as external reference inputs, shareable with analog inputs.
module sadc_control #(
  parameter int num_inputs = sadc_pkg::sadc_num_inputs
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [3:0] sample_hold,
  output logic [3:0] input_select,
  output logic [2:0] vref_select,
  output logic [15:0] analog_pin_enable,
  output logic conversion_irq
);
  // ******************************************************************
  // registers
  // ******************************************************************
  logic [15:0] converter_control_one;
  logic [15:0] converter_control_two;
  logic [15:0] converter_control_three;
  logic [15:0] analog_pin_config_low;
  logic [15:0] analog_pin_config_high;
  logic [0:0] irq_status;
  logic [0:0] irq_mask;
  logic [11:0] result;
  logic [3:0] channel;
  logic [4:0] bit_count;
  logic sampling;
  logic converting;
  logic conv_tick;
  logic [7:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;

  // ******************************************************************
  // decode
  // ******************************************************************
  wire logic module_on = converter_control_one[sadc_pkg::sadc_pos_module_on];
  wire logic high_res = converter_control_one[sadc_pkg::sadc_pos_resolution_select];
  wire logic simultaneous = converter_control_one[sadc_pkg::sadc_pos_simultaneous] & ~high_res;
  wire logic [1:0] channel_count = converter_control_two[sadc_pkg::sadc_pos_channels_lo +: 2];
  wire logic [7:0] clock_div = converter_control_three[sadc_pkg::sadc_pos_clock_div_lo +: 8];
  wire logic [4:0] conv_bits = high_res ? 5'(sadc_pkg::sadc_bits_high_res) : 5'(sadc_pkg::sadc_bits_low_res);
  wire logic do_write = aw_held & w_held & ~s_axi_bvalid;
  wire logic do_read = s_axi_arvalid & s_axi_arready;
  wire logic [7:0] r_addr = s_axi_araddr[7:0];
  wire logic start_req = do_write && aw_addr == sadc_pkg::sadc_off_control_one && w_strb[0]
    && w_data[sadc_pkg::sadc_pos_start];
  wire logic conv_done = converting && conv_tick && bit_count == conv_bits;
  wire logic status_read = do_read && r_addr == sadc_pkg::sadc_off_irq_status;
  wire logic [15:0] low_mask = w_strb[1] ? (w_strb[0] ? 16'hFFFF : 16'hFF00) : (w_strb[0] ? 16'h00FF : 16'h0000);
  wire logic [15:0] one_mask = module_on ? (low_mask & ~16'h0400) : low_mask;
  wire logic [3:0] last_channel = (num_inputs > 0) ? 4'(num_inputs - 1) : 4'h0;
  wire logic mapped = r_addr[1:0] == 2'h0 && r_addr <= sadc_pkg::sadc_off_result;
  wire logic aw_mapped = aw_addr[1:0] == 2'h0 && aw_addr <= sadc_pkg::sadc_off_irq_mask;
  logic [31:0] read_mux;

  // read data selection
  always_comb begin
    read_mux = 32'h0000_0000;
    unique case (r_addr)
      sadc_pkg::sadc_off_control_one: read_mux = {16'h0000, converter_control_one};
      sadc_pkg::sadc_off_control_two: read_mux = {16'h0000, converter_control_two};
      sadc_pkg::sadc_off_control_three: read_mux = {16'h0000, converter_control_three};
      sadc_pkg::sadc_off_pin_config_low: read_mux = {16'h0000, analog_pin_config_low};
      sadc_pkg::sadc_off_pin_config_high: read_mux = {16'h0000, analog_pin_config_high};
      sadc_pkg::sadc_off_irq_status: read_mux = {31'h0000_0000, irq_status};
      sadc_pkg::sadc_off_irq_mask: read_mux = {31'h0000_0000, irq_mask};
      sadc_pkg::sadc_off_result: read_mux = {20'h0_0000, result};
      default: read_mux = 32'h0000_0000;
    endcase
  end

  // ******************************************************************
  // axi4-lite write channel: address and data captured in either order
  // ******************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sadc_pkg::sadc_resp_okay;
    end else begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_held & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= aw_mapped ? sadc_pkg::sadc_resp_okay : sadc_pkg::sadc_resp_slverr;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi4-lite read channel: one read in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= sadc_pkg::sadc_resp_okay;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= read_mux;
        s_axi_rresp <= mapped ? sadc_pkg::sadc_resp_okay : sadc_pkg::sadc_resp_slverr;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ******************************************************************
  // configuration registers, written by software in the set-up order
  // ******************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      converter_control_one <= sadc_pkg::sadc_rst_control;
      converter_control_two <= sadc_pkg::sadc_rst_control;
      converter_control_three <= sadc_pkg::sadc_rst_control;
      analog_pin_config_low <= sadc_pkg::sadc_rst_pin_config;
      analog_pin_config_high <= sadc_pkg::sadc_rst_pin_config;
      irq_mask <= 1'b0;
    end else if (do_write) begin
      unique case (aw_addr)
        sadc_pkg::sadc_off_control_one:
          converter_control_one <= (converter_control_one & ~one_mask) | (w_data[15:0] & one_mask);
        sadc_pkg::sadc_off_control_two:
          converter_control_two <= (converter_control_two & ~low_mask) | (w_data[15:0] & low_mask);
        sadc_pkg::sadc_off_control_three:
          converter_control_three <= (converter_control_three & ~low_mask) | (w_data[15:0] & low_mask);
        sadc_pkg::sadc_off_pin_config_low:
          analog_pin_config_low <= (analog_pin_config_low & ~low_mask) | (w_data[15:0] & low_mask);
        sadc_pkg::sadc_off_pin_config_high:
          analog_pin_config_high <= (analog_pin_config_high & ~low_mask) | (w_data[15:0] & low_mask);
        sadc_pkg::sadc_off_irq_mask:
          if (w_strb[0]) begin
            irq_mask <= w_data[0:0];
          end
        default: ;
      endcase
    end
  end

  // ******************************************************************
  // sequencer: sample, then convert one bit per conversion clock tick
  // ******************************************************************
  sadc_clock_div u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(converting),
    .divisor(clock_div),
    .tick(conv_tick)
  );

  // switching the module off aborts any sample or conversion at once
  always_ff @(posedge aclk) begin
    if (!aresetn || !module_on) begin
      sampling <= 1'b0;
      converting <= 1'b0;
      bit_count <= 5'h00;
      sample_hold <= 4'h0;
    end else if (start_req && !sampling && !converting) begin
      sampling <= 1'b1;
      sample_hold <= simultaneous ? (4'hF >> (2'd3 - channel_count)) : 4'h1;
    end else if (sampling) begin
      sampling <= 1'b0;
      converting <= 1'b1;
      bit_count <= 5'h00;
      sample_hold <= 4'h0;
    end else if (converting && conv_tick) begin
      bit_count <= bit_count + 5'h01;
      if (conv_done) begin
        converting <= 1'b0;
      end
    end
  end

  // channel advance and result capture; the analog value itself is outside this block
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel <= 4'h0;
      result <= 12'h000;
    end else if (conv_done) begin
      channel <= (channel >= last_channel) ? 4'h0 : channel + 4'h1;
      result <= {8'h00, channel};
    end
  end

  // ******************************************************************
  // interrupt: set wins over the clear-on-read
  // ******************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= 1'b0;
      conversion_irq <= 1'b0;
    end else begin
      irq_status <= conv_done ? 1'b1 : (status_read ? 1'b0 : irq_status);
      conversion_irq <= |(irq_status & irq_mask);
    end
  end

  // pin-facing outputs come from flip-flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_select <= 4'h0;
      vref_select <= 3'h0;
      analog_pin_enable <= 16'h0000;
    end else begin
      input_select <= channel;
      vref_select <= converter_control_two[sadc_pkg::sadc_pos_vref_lo +: 3];
      analog_pin_enable <= analog_pin_config_low | analog_pin_config_high;
    end
  end
endmodule : sadc_control

/* sadc_control_sva.sv */
`timescale 1ns/1ns
// ****************************************************************
// port checker for the converter control block
// ****************************************************************
module sadc_control_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_wvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] sample_hold,
  input wire logic [3:0] input_select,
  input wire logic [2:0] vref_select,
  input wire logic [15:0] analog_pin_enable,
  input wire logic conversion_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic seen_sample;
  // an interrupt can only stem from a conversion, and a conversion always begins with a sample pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) seen_sample <= 1'b0;
    else if (sample_hold != 4'h0) seen_sample <= 1'b1;
  end
  property p_sh_pulse; sample_hold != 4'h0 |=> sample_hold == 4'h0; endproperty
  a_sh_pulse: assert property (p_sh_pulse) else $error("sample pulse longer than one cycle");
  property p_sh_shape; sample_hold != 4'h0 |-> sample_hold inside {4'h1, 4'h3, 4'h7, 4'hF}; endproperty
  a_sh_shape: assert property (p_sh_shape) else $error("sample amplifiers not a low group");
  property p_input_range; input_select <= 4'hC; endproperty
  a_input_range: assert property (p_input_range) else $error("input channel above twelve");
  // pin enable and reference outputs follow register writes only, with a short pipeline after the data beat
  property p_pins_follow_write;
    !$stable(analog_pin_enable) |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3);
  endproperty
  a_pins_follow_write: assert property (p_pins_follow_write) else $error("pin enable moved without a write");
  property p_vref_follow_write;
    !$stable(vref_select) |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3);
  endproperty
  a_vref_follow_write: assert property (p_vref_follow_write) else $error("reference moved without a write");
  property p_irq_after_sample; $rose(conversion_irq) |-> seen_sample; endproperty
  a_irq_after_sample: assert property (p_irq_after_sample) else $error("interrupt without any sampling");
  property p_bvalid_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped early");
  property p_rvalid_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data dropped early");
  property p_arready_cause; s_axi_arready |-> $past(s_axi_arvalid); endproperty
  a_arready_cause: assert property (p_arready_cause) else $error("read address taken unasked");
endmodule : sadc_control_sva

bind sadc_control sadc_control_sva i_sadc_control_sva (.aclk, .aresetn, .s_axi_wvalid, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .sample_hold, .input_select, .vref_select, .analog_pin_enable, .conversion_irq);

/* sadc_tb_top.sv */
`timescale 1ns/1ns
module sadc_control_tb_top;
  logic aclk = 0, aresetn = 0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 0, sample_hold, input_select, sh_last;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, conversion_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [2:0] vref_select;
  logic [15:0] analog_pin_enable;
  int n_mismatch = 0, compares = 0, cycles = 0, sh_count = 0, n0 = 0;
  // generous ceiling: the whole sequence needs well under a thousand cycles
  localparam int timeout_cycles = 6000;
  always #5 aclk = ~aclk;
  sadc_control i_sadc_control (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_hold,
    .input_select, .vref_select, .analog_pin_enable, .conversion_irq);
  // ****************************************************************
  // monitors and bounded run time
  // ****************************************************************
  // the sample pulse lasts one cycle, so it is caught here rather than by the sequence
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (sample_hold !== 4'h0) begin
      sh_last <= sample_hold;
      sh_count <= sh_count + 1;
    end
  end
  task stop_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  // ****************************************************************
  // bus tasks: every handshake is judged at the rising edge that completes it
  // ****************************************************************
  // response ready is raised late on purpose, so the slave has to hold its answer
  task axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= {24'h00_0000, a};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write
  task axi_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= {24'h00_0000, a};
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read
  // ****************************************************************
  // test sequence
  // ****************************************************************
  // ports are compared at falling edges, where they have settled
  task run_tests();
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    check({conversion_irq, analog_pin_enable, 8'h00, vref_select, sample_hold}, 32'h0, "port reset");
    check({28'h0, input_select}, 32'h0, "channel reset");
    for (int i = 0; i < 8; i++) begin
      axi_read(8'(i * 4), rd);
      check(rd, 32'h0, "register reset");
    end
    axi_read(8'h20, rd);
    check(rd, 32'h0, "unmapped data");
    check({30'h0, resp}, {30'h0, sadc_pkg::sadc_resp_slverr}, "unmapped resp");
    $display("test reset done");
    axi_write(sadc_pkg::sadc_off_pin_config_low, 32'h0000_1FFF);
    axi_write(sadc_pkg::sadc_off_pin_config_high, 32'h0000_2000);
    axi_write(sadc_pkg::sadc_off_control_two, 32'h0000_A300);
    repeat (2) @(negedge aclk);
    check({16'h0, analog_pin_enable}, 32'h0000_3FFF, "pin enable");
    check({29'h0, vref_select}, 32'h5, "reference");
    $display("test pins done");
    axi_write(sadc_pkg::sadc_off_control_one, 32'h0000_0400);
    axi_read(sadc_pkg::sadc_off_control_one, rd);
    check(rd, 32'h0000_0400, "resolution off");
    // a resolution change while running must not stick
    axi_write(sadc_pkg::sadc_off_control_one, 32'h0000_8400);
    axi_write(sadc_pkg::sadc_off_control_one, 32'h0000_8000);
    axi_read(sadc_pkg::sadc_off_control_one, rd);
    check(rd, 32'h0000_8400, "resolution frozen");
    axi_write(sadc_pkg::sadc_off_control_one, 32'h0000_0000);
    $display("test resolution done");
    // the module is switched on by a write of its own, and only then started
    n0 = sh_count;
    axi_write(sadc_pkg::sadc_off_control_three, 32'h0000_0001);
    axi_write(sadc_pkg::sadc_off_control_one, 32'h0000_0108);
    axi_write(sadc_pkg::sadc_off_control_one, 32'h0000_8108);
    axi_write(sadc_pkg::sadc_off_control_one, 32'h0000_810A);
    repeat (60) @(negedge aclk);
    check(sh_count - n0, 32'h1, "simultaneous count");
    check({28'h0, sh_last}, 32'hF, "four amplifiers");
    check({28'h0, input_select}, 32'h1, "channel advanced");
    check({31'h0, conversion_irq}, 32'h0, "masked irq");
    axi_write(sadc_pkg::sadc_off_irq_mask, 32'h1);
    repeat (3) @(negedge aclk);
    check({31'h0, conversion_irq}, 32'h1, "unmasked irq");
    axi_read(sadc_pkg::sadc_off_irq_status, rd);
    check(rd, 32'h1, "status set");
    repeat (3) @(negedge aclk);
    check({31'h0, conversion_irq}, 32'h0, "irq cleared");
    $display("test ten bit done");
    n0 = sh_count;
    axi_write(sadc_pkg::sadc_off_control_one, 32'h0000_0000);
    axi_write(sadc_pkg::sadc_off_control_one, 32'h0000_0408);
    axi_write(sadc_pkg::sadc_off_control_one, 32'h0000_8408);
    axi_write(sadc_pkg::sadc_off_control_one, 32'h0000_840A);
    repeat (60) @(negedge aclk);
    check(sh_count - n0, 32'h1, "single sample");
    check({28'h0, sh_last}, 32'h1, "single amplifier");
    check({28'h0, input_select}, 32'h2, "channel advanced again");
    axi_read(sadc_pkg::sadc_off_result, rd);
    check(rd, 32'h1, "result channel");
    axi_read(sadc_pkg::sadc_off_irq_status, rd);
    check(rd, 32'h1, "twelve bit done");
    $display("test twelve bit done");
    // start requested while the converter is off
    axi_write(sadc_pkg::sadc_off_control_one, 32'h0000_0000);
    n0 = sh_count;
    axi_write(sadc_pkg::sadc_off_control_one, 32'h0000_000A);
    repeat (60) @(negedge aclk);
    check(sh_count - n0, 32'h0, "no sampling off");
    axi_read(sadc_pkg::sadc_off_irq_status, rd);
    check(rd, 32'h0, "no flag off");
    $display("test off done");
  endtask : run_tests
  // the sequence races the cycle ceiling; a hang ends as a counted mismatch
  initial begin
    fork
      run_tests();
      wait (cycles == timeout_cycles);
    join_any
    if (cycles >= timeout_cycles) begin
      n_mismatch++;
      $display("mismatch at %0t: timeout", $time);
    end
    stop_test();
  end
endmodule : sadc_control_tb_top
